// file: pkg/ext_irq_pkg.sv
package ext_irq_pkg;

    localparam int NUM_CH = 6;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_EXT_EXT_IRQ_PIN_ONE_CONTROL  = 16'h0fd8;
    localparam logic [15:0] IDX_EXT_EXT_IRQ_PIN_TWO_CONTROL  = 16'h0fd9;
    localparam logic [15:0] IDX_EXT_EXT_IRQ_PIN_THREE_CONTROL  = 16'h0fda;
    localparam logic [15:0] IDX_EXT_EXT_IRQ_PIN_FOUR_CONTROL  = 16'h0fdb;
    localparam logic [15:0] IDX_LOW_POWER_GATE    = 16'h0fe0;
    localparam logic [15:0] IDX_PASS_LEVEL_STATUS = 16'h0fe1;

    // field positions
    localparam int LVL_BIT   = 4;
    localparam int TRIG_LSB  = 2;
    localparam int INTV_LSB  = 0;
    localparam int GATE_BIT  = 0;
    localparam int RSVD_LSB  = 5;
    localparam int RSVD_MSB  = 7;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic       GATE_RESET = 1'b0;
    localparam logic       LVL_RESET  = 1'b0;

    // timing
    localparam int GEAR_PERIOD_NS     = 10;
    localparam int LF_DIV_DEFAULT     = 8;
    localparam int SLOW_SAMPLE_LF     = 4;
    localparam int FAST_AGREE_SAMPLES = 3;
    localparam int SLOW_AGREE_SAMPLES = 2;

    typedef enum logic [1:0] {TRIG_RISE, TRIG_FALL, TRIG_BOTH, TRIG_HIGH} trig_sel_t;
    typedef enum logic [1:0] {INTV_GEAR, INTV_DIV4, INTV_DIV8, INTV_DIV16} interval_sel_t;
    typedef enum logic [1:0] {MODE_FULL_SPEED, MODE_LOW_SPEED, MODE_HALTED} power_mode_t;

    typedef struct packed {
        trig_sel_t     trig;
        interval_sel_t interval;
    } chan_cfg_t;

endpackage : ext_irq_pkg

// file: hw/irq_pin_filter.sv
`timescale 1ns/1ns
`default_nettype none
module irq_pin_filter
    import ext_irq_pkg::*;
#(
    parameter bit FIXED_FALL = 1'b0
)(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      pin_async,
    input  wire logic      active,
    input  wire logic      fast_mode,
    input  wire logic      fast_tick,
    input  wire logic      slow_tick,
    input  wire chan_cfg_t cfg,
    output logic           pass_level_q,
    output logic           req_q
);

    logic [2:0] sync_q;
    logic       pin_level_q;
    logic [2:0] smp_q;
    logic [2:0] hist_d;
    logic       tick;
    logic       agree;
    logic       change;

    // pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_q      <= 3'h0;
            pin_level_q <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[1:0], pin_async}; // [R22]
            if (sync_q[2] == sync_q[1])
                pin_level_q <= sync_q[2];
        end
    end

    always_comb
    begin
        tick   = active && (fast_mode ? (FIXED_FALL || fast_tick) : slow_tick); // [R4] [R20]
        hist_d = {smp_q[1:0], pin_level_q};
        if (fast_mode && !FIXED_FALL)
            agree = (hist_d == 3'h7) || (hist_d == 3'h0); // [R19] [R10]
        else
            agree = (hist_d[1] == hist_d[0]); // [R9] [R5] [R20]
        change = tick && agree && (hist_d[0] != pass_level_q);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            smp_q        <= 3'h0;
            pass_level_q <= 1'b0;
        end
        else if (tick)
        begin
            smp_q <= hist_d;
            if (agree)
                pass_level_q <= hist_d[0];
        end
    end

    // request generation on the filtered signal
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            req_q <= 1'b0;
        else if (!active)
            req_q <= 1'b0; // [R11] [R21]
        else if (FIXED_FALL)
            req_q <= change && pass_level_q; // [R7]
        else
            case (cfg.trig) // [R3] [R8]
                TRIG_RISE: req_q <= change && !pass_level_q;
                TRIG_FALL: req_q <= change && pass_level_q;
                TRIG_BOTH: req_q <= change;
                // level request moves with the filtered level, so the captured level agrees
                default:   req_q <= (tick && agree) ? hist_d[0] : pass_level_q;
            endcase
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence rise_seen;
        !pass_level_q ##1 pass_level_q;
    endsequence

    a_fast_three_agree: assert property ( // [R19]
        ($changed(pass_level_q) && !FIXED_FALL && $past(fast_mode))
        |-> smp_q == {3{pass_level_q}})
        else $error("configurable channel passed without three agreeing samples");

    a_two_agree: assert property ( // [R20]
        ($changed(pass_level_q) && (FIXED_FALL || !$past(fast_mode)))
        |-> smp_q[1:0] == {2{pass_level_q}})
        else $error("level passed without two agreeing samples");

    a_rise_request: assert property ( // [R3]
        ((active && cfg.trig == TRIG_RISE && !FIXED_FALL) ##0 rise_seen)
        |-> req_q)
        else $error("rising edge did not raise a request");

    a_fixed_no_rise: assert property ( // [R7]
        (FIXED_FALL && $rose(pass_level_q)) |-> !req_q)
        else $error("fixed channel fired on a rising edge");

endmodule : irq_pin_filter
`default_nettype wire

// file: hw/ext_irq_edge_noise_filter.sv
// Contract
// R1: ch4 control bit 4 is read-only, returns filtered level at last request.
// R2: captured level is refreshed on every request, showing which edge fired.
// R3: ch4 trigger field selects rising, falling, both edges or high level.
// R4: full-speed sampling interval is gear clock divided by 1, 4, 8 or 16.
// R5: slow modes reject pulses under 4 low-frequency periods, accept 8 or more.
// R6: bits 7 to 5 of the ch4 control register read zero.
// R7: channels 0 and 5 are fixed falling edge with fixed noise rejection.
// R8: channels 1 to 4 configurable; only ch4 has high-level trigger.
// R9: channels 0 and 5 at full speed reject under 1, accept 2 gear periods; the code accepts from 2, the synchroniser rejecting 1.
// R10: channels 1 to 4 reject under 2 intervals, accept 3 intervals plus 1.
// R11: clock gate bit 0 stops the logic; no external requests occur.
// R12: clock gate bit resets to 0.
// R13: software sets the clock gate before writing any control register.
// R14: a ch4 control write may cause a spurious request; mask it first.
// R15: toggling the clock gate may cause a spurious request; mask it first.
// R16: after entering slow mode, wait 12 low-frequency periods, clear the latch.
// R17: after leaving slow mode, wait 2 gear plus 3 intervals, clear the latch.
// R18: mask the request before changing operating mode.
// R19: full-speed configurable channel needs three consecutive agreeing samples.
// R20: slow modes sample at low-frequency clock over 4, two samples agree.
// R21: deep idle, deep sleep and stop halt sampling and requests.
// R22: each pin is synchronised by flip-flops before the noise canceller.
// R23: writes to read-only and reserved bits are ignored.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ext_irq_edge_noise_filter
    import ext_irq_pkg::*;
#(
    parameter int unsigned LF_DIV = LF_DIV_DEFAULT
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire power_mode_t power_mode,
    input  wire logic        ext_irq_pin_zero,
    input  wire logic        ext_irq_pin_one,
    input  wire logic        ext_irq_pin_two,
    input  wire logic        ext_irq_pin_three,
    input  wire logic        ext_irq_pin_four,
    input  wire logic        ext_irq_pin_five,
    output logic [NUM_CH-1:0] irq_req
);

    localparam int LFW = (LF_DIV > 2) ? $clog2(LF_DIV) : 1;

    if (LF_DIV < 2)
    begin : g_div_check
        $error("LF_DIV must be at least 2");
    end

    localparam logic [15:0] ADDR_CTRL1  = {IDX_EXT_EXT_IRQ_PIN_ONE_CONTROL[13:0], 2'b00};
    localparam logic [15:0] ADDR_CTRL2  = {IDX_EXT_EXT_IRQ_PIN_TWO_CONTROL[13:0], 2'b00};
    localparam logic [15:0] ADDR_CTRL3  = {IDX_EXT_EXT_IRQ_PIN_THREE_CONTROL[13:0], 2'b00};
    localparam logic [15:0] ADDR_CTRL4  = {IDX_EXT_EXT_IRQ_PIN_FOUR_CONTROL[13:0], 2'b00};
    localparam logic [15:0] ADDR_GATE   = {IDX_LOW_POWER_GATE[13:0], 2'b00};
    localparam logic [15:0] ADDR_STATUS = {IDX_PASS_LEVEL_STATUS[13:0], 2'b00};

    logic [NUM_CH-1:0] pins;
    logic [NUM_CH-1:0] pass_level;
    logic [NUM_CH-1:0] fast_tick;
    chan_cfg_t         cfg      [NUM_CH];
    chan_cfg_t         ctrl_q   [1:4];
    logic [4:1]        lvl_q;
    logic              gate_q;
    logic              active;
    logic              fast_mode;
    logic [LFW-1:0]    lf_cnt_q;
    logic [1:0]        slow_cnt_q;
    logic              slow_tick;
    logic [3:0]        gear_cnt_q;
    logic              setup;
    logic              wr_strobe;
    logic              hit;
    logic [2:0]        ctrl_sel;
    logic [31:0]       rd_d;

    assign pins = {ext_irq_pin_five, ext_irq_pin_four, ext_irq_pin_three,
                   ext_irq_pin_two, ext_irq_pin_one, ext_irq_pin_zero};

    // gate and mode decide whether the sampling logic runs
    assign active    = gate_q && (power_mode != MODE_HALTED); // [R11] [R21]
    assign fast_mode = (power_mode == MODE_FULL_SPEED);

    // low-frequency clock as an enable, then divided by four for slow sampling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lf_cnt_q   <= '0;
            slow_cnt_q <= 2'h0;
        end
        else if (active)
        begin
            if (lf_cnt_q == LFW'(LF_DIV - 1))
            begin
                lf_cnt_q   <= '0;
                slow_cnt_q <= slow_cnt_q + 2'h1;
            end
            else
                lf_cnt_q <= lf_cnt_q + LFW'(1);
        end
    end

    assign slow_tick = active && (lf_cnt_q == LFW'(LF_DIV - 1)) &&
                       (slow_cnt_q == 2'(SLOW_SAMPLE_LF - 1)); // [R20] [R5]

    // gear clock divider for the selectable sampling interval
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gear_cnt_q <= 4'h0;
        else if (active)
            gear_cnt_q <= gear_cnt_q + 4'h1;
    end

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++)
        begin : g_ch
            if (i == 0 || i == NUM_CH - 1)
            begin : g_fixed
                assign cfg[i]       = '{trig: TRIG_FALL, interval: INTV_GEAR}; // [R7]
                assign fast_tick[i] = 1'b1;
            end
            else
            begin : g_cfg
                always_comb
                begin
                    cfg[i] = ctrl_q[i];
                    if (i != 4 && ctrl_q[i].trig == TRIG_HIGH)
                        cfg[i].trig = TRIG_BOTH; // reserved code; channel is held inactive
                    case (ctrl_q[i].interval) // [R4]
                        INTV_GEAR: fast_tick[i] = 1'b1;
                        INTV_DIV4: fast_tick[i] = (gear_cnt_q[1:0] == 2'h0);
                        INTV_DIV8: fast_tick[i] = (gear_cnt_q[2:0] == 3'h0);
                        default:   fast_tick[i] = (gear_cnt_q == 4'h0);
                    endcase
                end
            end

            irq_pin_filter #(
                .FIXED_FALL (i == 0 || i == NUM_CH - 1)
            ) u_filter (
                .pclk         (pclk),
                .presetn      (presetn),
                .pin_async    (pins[i]),
                .active       (active && !(i != 4 && i != 0 && i != NUM_CH - 1 &&
                                           ctrl_q[(i % 4) + ((i == 0) ? 1 : 0)].trig
                                           == TRIG_HIGH)),
                .fast_mode    (fast_mode),
                .fast_tick    (fast_tick[i]),
                .slow_tick    (slow_tick),
                .cfg          (cfg[i]),
                .pass_level_q (pass_level[i]),
                .req_q        (irq_req[i])
            );
        end
    endgenerate

    // apb slave: one wait-free access, answered registered
    assign setup     = psel && !penable;
    assign wr_strobe = psel && penable && pready && pwrite && hit;

    always_comb
    begin
        hit      = 1'b1;
        ctrl_sel = 3'h0;
        rd_d     = 32'h0000_0000;
        if (paddr == ADDR_CTRL1)
            ctrl_sel = 3'h1;
        else if (paddr == ADDR_CTRL2)
            ctrl_sel = 3'h2;
        else if (paddr == ADDR_CTRL3)
            ctrl_sel = 3'h3;
        else if (paddr == ADDR_CTRL4)
            ctrl_sel = 3'h4;
        else if (paddr == ADDR_GATE)
            rd_d[GATE_BIT] = gate_q;
        else if (paddr == ADDR_STATUS)
            rd_d[NUM_CH-1:0] = pass_level;
        else
            hit = 1'b0;
        if (ctrl_sel != 3'h0)
        begin
            rd_d[LVL_BIT]              = lvl_q[ctrl_sel]; // [R1]
            rd_d[TRIG_LSB+1:TRIG_LSB]  = ctrl_q[ctrl_sel].trig;
            rd_d[INTV_LSB+1:INTV_LSB]  = ctrl_q[ctrl_sel].interval;
            rd_d[RSVD_MSB:RSVD_LSB]    = 3'h0; // [R6]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !hit;
            if (setup && !pwrite)
                prdata <= rd_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gate_q <= GATE_RESET; // [R12]
        else if (wr_strobe && paddr == ADDR_GATE)
            gate_q <= pwdata[GATE_BIT]; // [R11] [R15]
    end

    // only trigger and interval are writable; level and reserved bits ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int c = 1; c <= 4; c++)
                ctrl_q[c] <= chan_cfg_t'(CTRL_RESET[3:0]);
        end
        else if (wr_strobe && ctrl_sel != 3'h0)
        begin
            ctrl_q[ctrl_sel].trig     <= trig_sel_t'(pwdata[TRIG_LSB+1:TRIG_LSB]); // [R23] [R14]
            ctrl_q[ctrl_sel].interval <= interval_sel_t'(pwdata[INTV_LSB+1:INTV_LSB]);
        end
    end

    // captured filtered level, refreshed at every request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_q <= {4{LVL_RESET}};
        else
        begin
            for (int c = 1; c <= 4; c++)
                if (irq_req[c])
                    lvl_q[c] <= pass_level[c]; // [R1] [R2]
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence gate_held_off;
        !gate_q [*2];
    endsequence

    a_gate_blocks_req: assert property ( // [R11]
        gate_held_off |-> irq_req == '0)
        else $error("request raised while clock gate is off");

    a_gate_stays_off: assert property ( // [R12]
        (!gate_q && !(wr_strobe && paddr == ADDR_GATE)) |=> !gate_q)
        else $error("clock gate turned on without a write");

    a_halt_no_req: assert property ( // [R21]
        (power_mode == MODE_HALTED) |=> irq_req == '0)
        else $error("request raised in a halted mode");

    a_rsvd_read_zero: assert property ( // [R6]
        (setup && !pwrite && paddr == ADDR_CTRL4) |=> prdata[RSVD_MSB:RSVD_LSB] == 3'h0)
        else $error("reserved control bits read nonzero");

    a_lvl_write_ignored: assert property ( // [R23]
        (wr_strobe && paddr == ADDR_CTRL4 && !irq_req[4]) |=> lvl_q[4] == $past(lvl_q[4]))
        else $error("write disturbed captured level");

    a_lvl_follows_req: assert property ( // [R2]
        irq_req[4] |=> lvl_q[4] == $past(pass_level[4]))
        else $error("captured level not refreshed on request");

    a_level_trigger: assert property ( // [R3]
        (active && ctrl_q[4].trig == TRIG_HIGH) |=> irq_req[4] == pass_level[4])
        else $error("high-level request does not follow the filtered level");

    a_reserved_quiet: assert property ( // [R8]
        (ctrl_q[1].trig == TRIG_HIGH) |=> !irq_req[1])
        else $error("reserved trigger code raised a request");

    a_apb_answer: assert property (
        setup |=> (pready && penable) or !psel)
        else $error("apb access not answered in one cycle");

endmodule : ext_irq_edge_noise_filter
`default_nettype wire

// file: verif/ext_pin_source.sv
`timescale 1ns/1ns
`default_nettype none
module ext_pin_source (
    input  wire logic       pclk,
    output logic      [5:0] pins
);
    // pins idle high, as with external pull-ups
    initial pins = 6'h3f;

    // inverts one pin for len cycles, then restores it
    task automatic pulse(input int ch, input int len);
        @(posedge pclk);
        pins[ch] <= ~pins[ch];
        repeat (len) @(posedge pclk);
        pins[ch] <= ~pins[ch];
    endtask : pulse

    task automatic set_level(input int ch, input logic v);
        @(posedge pclk);
        pins[ch] <= v;
    endtask : set_level
endmodule : ext_pin_source
`default_nettype wire

// file: verif/tb_ext_irq_edge_noise_filter.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ext_irq_edge_noise_filter;
    import ext_irq_pkg::*;
    localparam int unsigned LF    = 2;
    localparam logic [15:0] A_C1  = 16'(IDX_EXT_EXT_IRQ_PIN_ONE_CONTROL << 2);
    localparam logic [15:0] A_C4  = 16'(IDX_EXT_EXT_IRQ_PIN_FOUR_CONTROL << 2);
    localparam logic [15:0] A_GT  = 16'(IDX_LOW_POWER_GATE << 2);
    localparam logic [15:0] A_BAD = 16'h0100;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic       [15:0] paddr;
    logic       [31:0] pwdata;
    logic       [31:0] prdata;
    logic              pready;
    logic              pslverr;
    power_mode_t       power_mode;
    logic        [5:0] pins;
    logic [NUM_CH-1:0] irq_req;
    logic       [32:0] exp_q [$];
    logic       [32:0] note;
    int                irq_cnt [NUM_CH];
    int                error_cnt;
    int                samples_checked;
    int                cycles;
    int unsigned       seed_val;
    int                d;

    ext_irq_edge_noise_filter #(.LF_DIV(LF)) ext_irq_edge_noise_filter_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
        .ext_irq_pin_zero(pins[0]), .ext_irq_pin_one(pins[1]),
        .ext_irq_pin_two(pins[2]), .ext_irq_pin_three(pins[3]),
        .ext_irq_pin_four(pins[4]), .ext_irq_pin_five(pins[5]),
        .irq_req(irq_req)
    );

    ext_pin_source ext_pin_source_inst (.pclk(pclk), .pins(pins));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask : wr

    // expected read word and error flag noted before the transfer
    task automatic rd(input logic [15:0] a, input logic [31:0] v, input logic err);
        exp_q.push_back({err, v});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // settle, pulse one pin, count requests; at_least compares a lower bound
    task automatic hit(input int ch, input int len, input int exp, input bit at_least);
        repeat (60) @(posedge pclk);
        irq_cnt[ch] = 0;
        ext_pin_source_inst.pulse(ch, len);
        repeat (80) @(posedge pclk);
        if (at_least)
            check("irq count min", {31'h0, irq_cnt[ch] >= exp}, 32'h1);
        else
            check("irq count", 32'(irq_cnt[ch]), 32'(exp));
    endtask : hit

    // results are judged at the falling edge, where outputs are settled
    always @(negedge pclk)
    begin
        for (int i = 0; i < NUM_CH; i++)
            if (irq_req[i] === 1'b1)
                irq_cnt[i]++;
        if (pready === 1'b1 && pwrite === 1'b0)
        begin
            if (exp_q.size() == 0)
                check("read note", 32'h0, 32'h1);
            else
            begin
                note = exp_q.pop_front();
                check("prdata", prdata, note[31:0]);
                check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            end
        end
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            results();
        end
    end

    initial
    begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0; pwdata = 32'h0;
        presetn = 1'b0; power_mode = MODE_FULL_SPEED;
        error_cnt = 0; samples_checked = 0; cycles = 0;
        irq_cnt = '{default: 0};
        seed_val = $urandom(32'he8a3);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_GT, 32'h0, 1'b0);
        rd(A_C4, 32'h0, 1'b0);
        rd(A_BAD, 32'h0, 1'b1);
        wr(A_BAD, 32'hffff_ffff);
        hit(0, 10, 0, 0);
        wr(A_GT, 32'h1);
        rd(A_GT, 32'h1, 1'b0);
        // the rise seen once the gate opens has already set the captured level
        wr(A_C4, 32'hffff_ffe7);
        rd(A_C4, 32'h17, 1'b0);
        hit(0, 10, 1, 0);
        hit(5, 10, 1, 0);
        // low pulse: rising fires at its end, falling at its start
        for (int t = 0; t < 3; t++)
        begin
            wr(A_C4, 32'(t << 2));
            hit(4, 10, (t == 2) ? 2 : 1, 0);
            rd(A_C4, 32'(((t != 1) << 4) | (t << 2)), 1'b0);
        end
        ext_pin_source_inst.set_level(4, 1'b0);
        wr(A_C4, 32'h0c);
        hit(4, 20, 12, 1);
        rd(A_C4, 32'h1c, 1'b0);
        ext_pin_source_inst.set_level(4, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            d = (i == 0) ? 1 : (1 << (i + 1));
            wr(A_C4, 32'(i));
            hit(4, 2 * d - 1, 0, 0);
            hit(4, 3 * d + 5, 1, 0);
        end
        wr(A_C1, 32'h08);
        hit(1, $urandom_range(40, 10), 2, 0);
        wr(A_C1, 32'h0c);
        hit(1, 10, 0, 0);
        power_mode <= MODE_LOW_SPEED;
        repeat (12 * LF) @(posedge pclk);
        hit(5, 4 * LF - 1, 0, 0);
        hit(0, 8 * LF + 4 + $urandom_range(8, 0), 1, 0);
        power_mode <= MODE_FULL_SPEED;
        hit(0, 10, 1, 0);
        power_mode <= MODE_HALTED;
        hit(0, 20, 0, 0);
        repeat (3) @(posedge pclk);
        results();
    end
endmodule : tb_ext_irq_edge_noise_filter
`default_nettype wire
